// File: design/key_scan_pkg.sv
/*
  package for the key matrix scan controller: register addresses, field
  positions, reset values and slot timing.
  assumes a 100 MHz reference clock.
*/
package key_scan_pkg;
  // ----------------------------------------------------------------------
  // addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] key_judge_addr = 8'h16;
  localparam logic [7:0] scan_source_addr = 8'h42;
  localparam logic [7:0] key_input_addr = 8'h73;
  localparam logic [7:0] display_mode_addr = 8'h17;
  localparam logic [7:0] port_select_addr = 8'h18;
  // ----------------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------------
  localparam int key_latched_bit = 0;
  localparam int display_enable_bit = 1;
  localparam int scan_enable_bit = 0;
  localparam int port_select_bit = 0;
  localparam logic [3:0] display_mode_reset = 4'h0;
  localparam logic [15:0] scan_source_reset = 16'h0000;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int clk_period_ns = 10;
  localparam int slot_time_us = 220;
  localparam int frame_time_ms = 4;
  localparam int slot_cycles = (slot_time_us * 1000) / clk_period_ns;
  localparam int frame_cycles = (frame_time_ms * 1000000) / clk_period_ns;
  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic display_enable;
    logic scan_enable;
    logic port_select;
  } mode_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } periph_req_t;
endpackage : key_scan_pkg

// File: design/scan_sync2.sv
/*
  two flip-flop synchroniser for a bus of levels.
  assumes inputs arrive asynchronously to the clock.
*/
`timescale 1ns/10ps
`default_nettype none
module scan_sync2 #(
  parameter int width = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [width-1:0] d_in,
  output logic [width-1:0] q_out
);
  logic [width-1:0] stage1;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage1 <= '0;
      q_out <= '0;
    end else begin
      stage1 <= d_in;
      q_out <= stage1;
    end
  end
endmodule : scan_sync2
`default_nettype wire

// File: design/scan_slot_timer.sv
/*
  frame timer producing the key source slot window.
  assumes one clock; counts up to 32 bits wide are parameters.
*/
`timescale 1ns/10ps
`default_nettype none
module scan_slot_timer #(
  parameter int frame_cycles = key_scan_pkg::frame_cycles,
  parameter int slot_cycles = key_scan_pkg::slot_cycles
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  output logic slot_out,
  output logic slot_end_out
);
  initial begin
    if (slot_cycles < 1 || slot_cycles >= frame_cycles) begin
      $error("slot must be shorter than frame");
    end
  end
  logic [31:0] count;
  // ----------------------------------------------------------------------
  // frame counter, slot at its start
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= 32'h00000000;
    end else if (!run_in || count == 32'(frame_cycles - 1)) begin
      count <= 32'h00000000;
    end else begin
      count <= count + 32'h00000001;
    end
  end
  assign slot_out = run_in && (count < 32'(slot_cycles));
  assign slot_end_out = run_in && (count == 32'(slot_cycles - 1));
endmodule : scan_slot_timer
`default_nettype wire

// File: design/key_matrix_scan_controller.sv
/*
  key matrix scan controller: shares sixteen segment pins between segment
  drive, key source slots and a general output port; latches four key inputs.
  assumes segment data comes from the display generator on the same clock,
  peripheral requests are single-cycle strobes, key pins are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
// Contract
// RQ1 - port select 1 makes pins general outputs
// RQ2 - software clears port select before scanning
// RQ3 - port output overrides segment and key drive
// RQ4 - segments driven only while display enabled
// RQ5 - display off: pins low, no pulses
// RQ6 - pulses need scan enable, display, segment mode
// RQ7 - 220 us slot every 4 ms
// RQ8 - slot drives each pin from source bit
// RQ9 - other segment pins drive 0 in slot
// RQ10 - pull-downs on only during slot
// RQ11 - key pins latched only during slot
// RQ12 - flag sets after slot following data write
// RQ13 - source data write clears flag
// RQ14 - reading flag returns and clears it
// RQ15 - flag lives in judge register 16H
// RQ16 - software writes, polls flag, reads keys
// RQ17 - sixteen sources by four inputs, 64 keys
// RQ18 - source data at 42H, also port data
// RQ19 - key inputs readable at 73H
// RQ20 - mode flags clear on stop, keep on CE
// RQ21 - outside slot pins carry segment data
module key_matrix_scan_controller #(
  parameter int source_lines = 16,
  parameter int key_lines = 4,
  parameter int extra_segments = 14,
  parameter int frame_cycles = key_scan_pkg::frame_cycles,
  parameter int slot_cycles = key_scan_pkg::slot_cycles
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clock_stop_reset_in,
  input wire logic ce_reset_in,
  input wire key_scan_pkg::periph_req_t req_in,
  output logic [15:0] rdata_out,
  input wire logic [source_lines-1:0] seg_data_in,
  input wire logic [extra_segments-1:0] extra_seg_data_in,
  input wire logic [key_lines-1:0] key_pins_in,
  output logic [source_lines-1:0] scan_pins_out,
  output logic [extra_segments-1:0] extra_seg_pins_out,
  output logic [key_lines-1:0] pulldown_enable_out,
  output logic key_latched_flag_out
);
  initial begin
    if (source_lines != 16 || key_lines != 4) begin
      $error("scan matrix is sixteen sources by four inputs"); // see RQ17
    end
    if (slot_cycles < 4 || slot_cycles >= frame_cycles) begin
      $error("slot must outlast the key input delay and fit in a frame");
    end
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  key_scan_pkg::mode_t mode;
  logic [source_lines-1:0] scan_source_data_register;
  logic [key_lines-1:0] key_input_port;
  logic key_latched_flag;
  logic slot_seen;
  logic slot;
  logic slot_end;
  logic scan_run;
  logic [key_lines-1:0] keys_sync;
  logic source_write;
  logic judge_read;
  logic slot_q;
  logic slot_start;
  logic [15:0] next_rdata;
  logic [source_lines-1:0] next_scan_pins;
  logic [extra_segments-1:0] next_extra_pins;

  assign source_write = req_in.wr && req_in.addr == key_scan_pkg::scan_source_addr;
  assign judge_read = req_in.rd && req_in.addr == key_scan_pkg::key_judge_addr;
  assign scan_run = mode.display_enable && mode.scan_enable && !mode.port_select; // see RQ6 see RQ2

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  scan_sync2 #(
    .width(key_lines)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .d_in(key_pins_in),
    .q_out(keys_sync)
  );

  scan_slot_timer #(
    .frame_cycles(frame_cycles),
    .slot_cycles(slot_cycles)
  ) u_timer (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .run_in(scan_run),
    .slot_out(slot),
    .slot_end_out(slot_end)
  ); // see RQ7

  // ----------------------------------------------------------------------
  // mode flags
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode <= '0;
    end else if (clock_stop_reset_in) begin
      mode <= '0; // see RQ20
    end else if (ce_reset_in) begin
      mode <= mode; // see RQ20
    end else if (req_in.wr && req_in.addr == key_scan_pkg::display_mode_addr) begin
      mode.display_enable <= req_in.wdata[key_scan_pkg::display_enable_bit];
      mode.scan_enable <= req_in.wdata[key_scan_pkg::scan_enable_bit];
    end else if (req_in.wr && req_in.addr == key_scan_pkg::port_select_addr) begin
      mode.port_select <= req_in.wdata[key_scan_pkg::port_select_bit];
    end
  end

  // ----------------------------------------------------------------------
  // source data register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scan_source_data_register <= key_scan_pkg::scan_source_reset;
    end else if (source_write) begin
      scan_source_data_register <= req_in.wdata[source_lines-1:0]; // see RQ18
    end
  end

  // ----------------------------------------------------------------------
  // key latch
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      key_input_port <= '0;
    end else if (slot) begin
      key_input_port <= keys_sync; // see RQ11
    end
  end

  // ----------------------------------------------------------------------
  // slot start: a slot counts only if it begins after the write
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      slot_q <= 1'b0;
    end else begin
      slot_q <= slot;
    end
  end
  assign slot_start = slot && !slot_q;

  // ----------------------------------------------------------------------
  // latched flag: a slot must start after the write
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      slot_seen <= 1'b0;
    end else if (source_write) begin
      slot_seen <= 1'b0;
    end else if (slot_start) begin
      slot_seen <= 1'b1;
    end else if (!slot) begin
      slot_seen <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      key_latched_flag <= 1'b0;
    end else if (slot_end && slot_seen && !source_write) begin
      key_latched_flag <= 1'b1; // see RQ12
    end else if (source_write || judge_read) begin
      key_latched_flag <= 1'b0; // see RQ13 see RQ14
    end
  end
  assign key_latched_flag_out = key_latched_flag;

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = 16'h0000;
    unique case (req_in.addr)
      key_scan_pkg::key_judge_addr: next_rdata[key_scan_pkg::key_latched_bit] = key_latched_flag; // see RQ15 see RQ14
      key_scan_pkg::key_input_addr: next_rdata[key_lines-1:0] = key_input_port; // see RQ19
      key_scan_pkg::scan_source_addr: next_rdata[source_lines-1:0] = scan_source_data_register;
      key_scan_pkg::display_mode_addr: begin
        next_rdata[key_scan_pkg::display_enable_bit] = mode.display_enable;
        next_rdata[key_scan_pkg::scan_enable_bit] = mode.scan_enable;
      end
      key_scan_pkg::port_select_addr: next_rdata[key_scan_pkg::port_select_bit] = mode.port_select;
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 16'h0000;
    end else if (req_in.rd) begin
      rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // pin drive: next level of each shared pin
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < source_lines; i++) begin : g_scan_pin
    logic next_level;
    always_comb begin
      if (mode.port_select) begin
        next_level = scan_source_data_register[i]; // see RQ1 see RQ3
      end else if (!mode.display_enable) begin
        next_level = 1'b0; // see RQ5
      end else if (slot) begin
        next_level = scan_source_data_register[i]; // see RQ8
      end else begin
        next_level = seg_data_in[i]; // see RQ4 see RQ21
      end
    end
    assign next_scan_pins[i] = next_level;
  end

  // ----------------------------------------------------------------------
  // pin drive: next level of each other segment pin
  // ----------------------------------------------------------------------
  for (genvar j = 0; j < extra_segments; j++) begin : g_extra_pin
    logic next_level;
    always_comb begin
      if (!mode.display_enable) begin
        next_level = 1'b0; // see RQ5
      end else if (slot) begin
        next_level = 1'b0; // see RQ9
      end else begin
        next_level = extra_seg_data_in[j]; // see RQ4
      end
    end
    assign next_extra_pins[j] = next_level;
  end

  // ----------------------------------------------------------------------
  // pin registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scan_pins_out <= '0;
    end else begin
      scan_pins_out <= next_scan_pins;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      extra_seg_pins_out <= '0;
    end else begin
      extra_seg_pins_out <= next_extra_pins;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pulldown_enable_out <= '0;
    end else begin
      pulldown_enable_out <= {key_lines{slot}}; // see RQ10
    end
  end
endmodule : key_matrix_scan_controller
`default_nettype wire

// File: tb/key_scan_props.sv
/* port checker for the key matrix scan controller.
   assumes single-cycle peripheral strobes and the bench's short frame counts. */
`timescale 1ns/10ps
`default_nettype none
module key_scan_props #(
  parameter int source_lines = 16,
  parameter int key_lines = 4,
  parameter int extra_segments = 14,
  parameter int frame_cycles = 40,
  parameter int slot_cycles = 5
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clock_stop_reset_in,
  input wire logic ce_reset_in,
  input wire key_scan_pkg::periph_req_t req_in,
  input wire logic [15:0] rdata_out,
  input wire logic [source_lines-1:0] scan_pins_out,
  input wire logic [extra_segments-1:0] extra_seg_pins_out,
  input wire logic [key_lines-1:0] pulldown_enable_out,
  input wire logic key_latched_flag_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic [source_lines-1:0] src;
  int hi;
  int per;
  logic seen;
  wire logic pd = pulldown_enable_out[0];
  wire logic wr_src = req_in.wr && req_in.addr == key_scan_pkg::scan_source_addr;
  wire logic rd_flag = req_in.rd && req_in.addr == key_scan_pkg::key_judge_addr;
  wire logic wr_mode = req_in.wr && req_in.addr inside {key_scan_pkg::display_mode_addr, key_scan_pkg::port_select_addr};
  // slot length, frame period and the source data seen at the pins
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      src <= '0;
      hi <= 0;
      per <= 0;
      seen <= 1'b0;
    end else begin
      if (wr_src) src <= req_in.wdata[source_lines-1:0];
      hi <= pd ? hi + 1 : 0;
      per <= $rose(pd) ? 1 : per + 1;
      if (wr_mode || clock_stop_reset_in || ce_reset_in) seen <= 1'b0;
      else if ($rose(pd)) seen <= 1'b1;
    end
  end
  property p_slot_len; $fell(pd) && seen |-> hi == slot_cycles; endproperty
  a_slot_len: assert property (p_slot_len) else $error("slot length wrong");
  property p_frame; $rose(pd) && seen |-> per == frame_cycles; endproperty
  a_frame: assert property (p_frame) else $error("frame period wrong");
  property p_pd_all; pulldown_enable_out != '0 |-> &pulldown_enable_out; endproperty
  a_pd_all: assert property (p_pd_all) else $error("pull-downs not together");
  property p_slot_pins; pd |-> scan_pins_out == $past(src) && extra_seg_pins_out == '0; endproperty
  a_slot_pins: assert property (p_slot_pins) else $error("slot pin levels wrong");
  property p_wr_clr; wr_src |=> !key_latched_flag_out; endproperty
  a_wr_clr: assert property (p_wr_clr) else $error("flag kept after source write");
  property p_rd_val; rd_flag |=> rdata_out[0] == $past(key_latched_flag_out); endproperty
  a_rd_val: assert property (p_rd_val) else $error("flag read value wrong");
  property p_rd_clr; rd_flag && !pd |=> !key_latched_flag_out; endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("flag kept after read");
  property p_unmapped; req_in.rd && req_in.addr == 8'h55 |=> rdata_out == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_flag_rise; $rose(key_latched_flag_out) |-> pd || $past(pd); endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag set away from slot end");
endmodule : key_scan_props
bind key_matrix_scan_controller key_scan_props #(.source_lines(source_lines), .key_lines(key_lines),
  .extra_segments(extra_segments), .frame_cycles(frame_cycles), .slot_cycles(slot_cycles)) key_scan_props_inst (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .clock_stop_reset_in(clock_stop_reset_in), .ce_reset_in(ce_reset_in),
  .req_in(req_in), .rdata_out(rdata_out), .scan_pins_out(scan_pins_out), .extra_seg_pins_out(extra_seg_pins_out),
  .pulldown_enable_out(pulldown_enable_out), .key_latched_flag_out(key_latched_flag_out));
`default_nettype wire

// File: tb/key_matrix_model.sv
/* key matrix of switches and diodes: sixteen source lines by four inputs.
   assumes undriven inputs float when the pull-downs are off. */
`timescale 1ns/10ps
`default_nettype none
module key_matrix_model (
  input wire logic ref_clk_in,
  input wire logic [15:0] scan_pins_in,
  input wire logic [3:0] pulldown_in,
  input wire logic [63:0] pressed_in,
  output logic [3:0] key_pins_out
);
  logic flt = 1'b0;
  always_ff @(posedge ref_clk_in) flt <= !flt;
  // a closed switch passes a high source level; otherwise pulled low or floating
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      key_pins_out[k] = |(scan_pins_in & pressed_in[k*16 +: 16]) | (!pulldown_in[k] & flt);
    end
  end
endmodule : key_matrix_model
`default_nettype wire

// File: tb/key_matrix_scan_controller_bench.sv
/* self-checking bench for the key matrix scan controller.
   assumes short frame and slot counts and the key matrix model. */
`timescale 1ns/10ps
`default_nettype none
module key_matrix_scan_controller_bench;
  localparam int fc = 40;
  localparam logic [15:0] seg = 16'h3C5A;
  localparam logic [13:0] xseg = 14'h1A5B;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cs_rst = 1'b0;
  logic ce_rst = 1'b0;
  key_scan_pkg::periph_req_t req = '0;
  logic [15:0] rdata, pins, d;
  logic [13:0] xpins;
  logic [3:0] keys, pd;
  logic flag;
  logic [63:0] pressed = 64'h0;
  int miscompares = 0;
  int n_compared = 0;
  initial forever #5 ref_clk_in = !ref_clk_in;
  key_matrix_scan_controller #(.frame_cycles(fc), .slot_cycles(5)) key_matrix_scan_controller_inst (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .clock_stop_reset_in(cs_rst), .ce_reset_in(ce_rst), .req_in(req),
    .rdata_out(rdata), .seg_data_in(seg), .extra_seg_data_in(xseg), .key_pins_in(keys), .scan_pins_out(pins),
    .extra_seg_pins_out(xpins), .pulldown_enable_out(pd), .key_latched_flag_out(flag));
  key_matrix_model key_matrix_model_inst (.ref_clk_in(ref_clk_in), .scan_pins_in(pins), .pulldown_in(pd),
    .pressed_in(pressed), .key_pins_out(keys));
  task automatic finish_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk_in);
    req <= '{1'b1, 1'b0, a, v};
    @(posedge ref_clk_in);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_in);
    req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk_in);
    req <= '0;
    #1 d = rdata;
  endtask : rd
  task automatic quiet(input string n);
    logic [3:0] acc;
    acc = 4'h0;
    repeat (2 * fc) begin
      cyc(1);
      acc = acc | pd;
    end
    chk(n, 16'h0000, {12'h000, acc});
  endtask : quiet
  task automatic wait_flag();
    for (int i = 0; i < 4 * fc && flag !== 1'b1; i++) cyc(1);
    chk("flag", 16'h0001, {15'h0000, flag});
    if (flag !== 1'b1) finish_test();
  endtask : wait_flag
  task automatic t_reset();
    chk("pins", 16'h0000, pins);
    rd(8'h17);
    chk("mode", 16'h0000, d);
    rd(8'h55);
    chk("unmapped", 16'h0000, d);
  endtask : t_reset
  task automatic t_off();
    wr(8'h42, 16'hA5C3);
    wr(8'h17, 16'h0001);
    quiet("pulldown");
    chk("pins", 16'h0000, pins);
    chk("flag", 16'h0000, {15'h0000, flag});
  endtask : t_off
  task automatic t_seg();
    wr(8'h17, 16'h0002);
    quiet("pulldown");
    chk("pins", seg, pins);
    chk("xpins", {2'b00, xseg}, {2'b00, xpins});
  endtask : t_seg
  task automatic t_scan();
    pressed <= 64'h0000_0008_0000_0200;
    wr(8'h18, 16'h0000);
    wr(8'h42, 16'h0008);
    wr(8'h17, 16'h0003);
    wait_flag();
    rd(8'h73);
    chk("keys", 16'h0004, d);
    rd(8'h16);
    chk("judge", 16'h0001, d);
    chk("flag", 16'h0000, {15'h0000, flag});
    wait_flag();
    wr(8'h42, 16'h0200);
    #1 chk("flag", 16'h0000, {15'h0000, flag});
    wait_flag();
    rd(8'h73);
    chk("keys", 16'h0001, d);
  endtask : t_scan
  task automatic t_port();
    wr(8'h18, 16'h0001);
    quiet("pulldown");
    chk("pins", 16'h0200, pins);
    wr(8'h18, 16'h0000);
  endtask : t_port
  task automatic t_midslot();
    for (int i = 0; i < 2 * fc && pd !== 4'hF; i++) cyc(1);
    chk("pulldown", 16'h000F, {12'h000, pd});
    if (pd !== 4'hF) finish_test();
    wr(8'h42, 16'h0008);
    cyc(8);
    chk("flag", 16'h0000, {15'h0000, flag});
    wait_flag();
    rd(8'h73);
    chk("keys", 16'h0004, d);
  endtask : t_midslot
  task automatic t_resets();
    @(posedge ref_clk_in);
    ce_rst <= 1'b1;
    @(posedge ref_clk_in);
    ce_rst <= 1'b0;
    rd(8'h17);
    chk("mode", 16'h0003, d);
    @(posedge ref_clk_in);
    cs_rst <= 1'b1;
    @(posedge ref_clk_in);
    cs_rst <= 1'b0;
    rd(8'h17);
    chk("mode", 16'h0000, d);
    cyc(3);
    chk("pins", 16'h0000, pins);
  endtask : t_resets
  initial begin
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    cyc(2);
    t_reset();
    t_off();
    t_seg();
    t_scan();
    t_port();
    t_midslot();
    t_resets();
    finish_test();
  end
endmodule : key_matrix_scan_controller_bench
`default_nettype wire
